/* File: bench/pcm_ctrl_model.sv */
`timescale 1ns/1ps
`include "pcm_regs.vh"

// Command-port master standing in for the system controller
module pcm_ctrl_model
(
   input  wire       mclk_i,
   input  wire       rd_valid_i,
   input  wire [7:0] rd_data_i,
   output reg        cmd_valid_o,
   output reg  [3:0] cmd_code_o,
   output reg  [7:0] cmd_wdata_o
);
   initial
   begin
      cmd_valid_o = 1'b0;
      cmd_code_o  = 4'h0;
      cmd_wdata_o = 8'h00;
   end

   // One command for one cycle; idle lines show the inverse so stale data is never reused
   task send(input logic [3:0] code, input logic [7:0] data);
      logic [7:0] d;
      begin
         d = data;
         if (code == `PCM_CMD_WR_CLOCK)
            d[5] = 1'b0;
         @(posedge mclk_i);
         cmd_valid_o <= 1'b1;
         cmd_code_o  <= code;
         cmd_wdata_o <= d;
         @(posedge mclk_i);
         cmd_valid_o <= 1'b0;
         cmd_code_o  <= ~code;
         cmd_wdata_o <= ~d;
      end
   endtask

   // Answer is taken one edge after the command edge
   task fetch(input logic [3:0] code, output logic ok, output logic [7:0] data);
      begin
         send(code, 8'h00);
         @(posedge mclk_i);
         ok   = rd_valid_i;
         data = rd_data_i;
      end
   endtask
endmodule

/* File: bench/pcm_regs_asserts.sv */
`timescale 1ns/1ps
`include "pcm_regs.vh"

// Port-level checks of the register core
module pcm_regs_asserts
(
   input wire       mclk_i,
   input wire       reset_i,
   input wire       cmd_valid_i,
   input wire [3:0] cmd_code_i,
   input wire [7:0] cmd_wdata_i,
   input wire       rd_valid_o,
   input wire [7:0] rd_data_o,
   input wire       tick_in_i,
   input wire       tick_out_o,
   input wire       supply_ok_i,
   input wire [7:0] sense_hit_i,
   input wire [7:0] near_target_i,
   input wire [7:0] at_final_i,
   input wire [7:0] sample_sel_o,
   input wire [7:0] fast_start_o,
   input wire [7:0] fine_charge_o,
   input wire [7:0] counters_en_o,
   input wire       regulator_off_o,
   input wire       osc_power_down_o
);
   reg        tout_sh_r;
   reg        mode_sh_r;
   reg  [7:0] mask_sh_r;
   reg  [7:0] new_r;
   reg  [7:0] last_r;
   wire       wr_clk = cmd_valid_i && cmd_code_i == `PCM_CMD_WR_CLOCK;
   wire       wr_msk = cmd_valid_i && cmd_code_i == `PCM_CMD_WR_MASK;
   wire       wr_cfg = cmd_valid_i && cmd_code_i == `PCM_CMD_WR_CONFIG;
   wire       rd_cmd = cmd_valid_i && (cmd_code_i == `PCM_CMD_RD_SENSE
                       || cmd_code_i == `PCM_CMD_RD_CLOCK || cmd_code_i == `PCM_CMD_RD_MASK
                       || cmd_code_i == `PCM_CMD_RD_CONFIG);

   // Shadows of written bits; order tracking restarts whenever the sampler may jump
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         tout_sh_r <= 1'b0;
         mode_sh_r <= 1'b0;
         mask_sh_r <= 8'hff;
         new_r     <= 8'h00;
         last_r    <= 8'h00;
      end
      else
      begin
         tout_sh_r <= wr_clk ? cmd_wdata_i[7] : tout_sh_r;
         mode_sh_r <= wr_cfg ? cmd_wdata_i[0] : mode_sh_r;
         mask_sh_r <= wr_msk ? cmd_wdata_i : mask_sh_r;
         new_r     <= wr_msk ? (cmd_wdata_i & ~mask_sh_r) : 8'h00;
         last_r    <= (!supply_ok_i || wr_cfg) ? 8'h00 :
                      (sample_sel_o != 8'h00) ? sample_sel_o : last_r;
      end
   end

   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);

   read_answer_a: assert property (rd_cmd |=> rd_valid_o)
      else $error("read command without answer");
   no_answer_a: assert property (!rd_cmd |=> !rd_valid_o)
      else $error("answer without read command");
   osc_stop_a: assert property (wr_clk |=> osc_power_down_o == $past(cmd_wdata_i[6]))
      else $error("oscillator stop does not follow bit six");
   reg_off_a: assert property (wr_cfg |=> regulator_off_o == $past(cmd_wdata_i[2]))
      else $error("regulator off does not follow config write");
   tick_quiet_a: assert property ((!tout_sh_r)[*3] |-> !tick_out_o)
      else $error("clock output moves while disabled");
   strobe_single_a: assert property ($onehot0(sample_sel_o))
      else $error("more than one channel strobed");
   strobe_order_a: assert property ((sample_sel_o != 8'h00 && last_r != 8'h00 && !mode_sh_r)
      |-> sample_sel_o == {last_r[6:0], last_r[7]})
      else $error("channel strobe out of order");
   idle_sampler_a: assert property ((!supply_ok_i)[*2] |-> sample_sel_o == 8'h00)
      else $error("sampling while internal supply is off");
   seq_off_a: assert property ((!supply_ok_i)[*2]
      |-> (fast_start_o | fine_charge_o | counters_en_o) == 8'h00)
      else $error("start-up state active without supply");
   one_state_a: assert property (((fast_start_o & fine_charge_o) | (fast_start_o & counters_en_o)
      | (fine_charge_o & counters_en_o)) == 8'h00)
      else $error("channel in two start-up phases");
   restart_fast_a: assert property ((new_r != 8'h00 && supply_ok_i) ##1 supply_ok_i ##1 supply_ok_i
      |-> (fast_start_o & $past(new_r, 2)) == $past(new_r, 2))
      else $error("newly enabled channel not in fast start");
endmodule

bind pcm_top pcm_regs_asserts chk_u
(
   .mclk_i(mclk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
   .cmd_wdata_i(cmd_wdata_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
   .tick_in_i(tick_in_i), .tick_out_o(tick_out_o), .supply_ok_i(supply_ok_i),
   .sense_hit_i(sense_hit_i), .near_target_i(near_target_i), .at_final_i(at_final_i),
   .sample_sel_o(sample_sel_o), .fast_start_o(fast_start_o), .fine_charge_o(fine_charge_o),
   .counters_en_o(counters_en_o), .regulator_off_o(regulator_off_o),
   .osc_power_down_o(osc_power_down_o)
);

/* File: bench/tb.sv */
`timescale 1ns/1ps
`include "pcm_regs.vh"

module tb;
   reg        mclk_i = 1'b0;
   reg        reset_i = 1'b1;
   reg        tick_in_i = 1'b0;
   reg        supply_ok_i = 1'b1;
   reg  [7:0] sense_hit_i = 8'h00;
   reg  [7:0] near_target_i = 8'h00;
   reg  [7:0] at_final_i = 8'h00;
   reg        tin_run = 1'b0;
   reg        tin_div = 1'b0;
   wire       cmd_valid, rd_valid, tick_out_o, regulator_off_o, osc_power_down_o;
   wire [3:0] cmd_code;
   wire [7:0] cmd_wdata, rd_data, sample_sel_o, fast_start_o, fine_charge_o, counters_en_o;
   integer    error_cnt = 0;
   integer    n_compared = 0;
   integer    cyc = 0;
   integer    g, e;
   logic      ok;
   logic [7:0] s, p, acc;
   real       mul [0:7] = '{0.5, 0.625, 0.75, 0.875, 1.0, 1.25, 1.5, 1.75};
   integer    dv [0:3] = '{64, 16, 4, 1};
   logic [7:0] cv [0:2] = '{8'h7b, 8'h84, 8'h0c};
   logic [7:0] mv [0:2] = '{8'h00, 8'ha5, 8'hff};
   logic [7:0] ov [0:1] = '{8'h9f, 8'h94};

   pcm_ctrl_model ctrl_u (.mclk_i(mclk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
      .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code), .cmd_wdata_o(cmd_wdata));
   pcm_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid),
      .cmd_code_i(cmd_code), .cmd_wdata_i(cmd_wdata), .rd_valid_o(rd_valid),
      .rd_data_o(rd_data), .tick_in_i(tick_in_i), .tick_out_o(tick_out_o),
      .supply_ok_i(supply_ok_i), .sense_hit_i(sense_hit_i), .near_target_i(near_target_i),
      .at_final_i(at_final_i), .sample_sel_o(sample_sel_o), .fast_start_o(fast_start_o),
      .fine_charge_o(fine_charge_o), .counters_en_o(counters_en_o),
      .regulator_off_o(regulator_off_o), .osc_power_down_o(osc_power_down_o));

   always #2 mclk_i = ~mclk_i;

   // Secondary clock: falling edge every four cycles, still when not running
   always @(posedge mclk_i)
   begin
      tin_div <= ~tin_div;
      if (tin_run && tin_div)
         tick_in_i <= ~tick_in_i;
   end

   // Hang guard sized well above the oscillator measurements
   always @(posedge mclk_i)
   begin
      cyc = cyc + 1;
      if (cyc == 80000)
      begin
         error_cnt = error_cnt + 1;
         conclude();
      end
   end

   task conclude;
      begin
         $display("compared %0d, wrong %0d", n_compared, error_cnt);
         if (error_cnt == 0 && n_compared > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask

   task cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
      begin
         n_compared = n_compared + 1;
         if (got !== exp)
         begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
         end
      end
   endtask

   task cmp_rng(input integer got, input integer lo, input integer hi, input string msg);
      begin
         n_compared = n_compared + 1;
         if (got < lo || got > hi)
         begin
            error_cnt = error_cnt + 1;
            $display("wrong value at %0t: %s got %0d expected %0d..%0d", $time, msg, got, lo, hi);
         end
      end
   endtask

   task rd(input logic [3:0] code, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      begin
         ctrl_u.fetch(code, ok, d);
         cmp8({7'h00, ok}, 8'h01, msg);
         cmp8(d, exp, msg);
      end
   endtask

   // Cycles to the next strobe, bounded
   task next_strobe(output integer gap, output logic [7:0] sel);
      begin
         gap = 0;
         do
         begin
            @(posedge mclk_i);
            gap = gap + 1;
         end
         while (sample_sel_o === 8'h00 && gap < 5000);
         sel = sample_sel_o;
      end
   endtask

   // Clock output half period; third gap only, as enabling the pin or a new
   // setting can make the first two gaps short
   task out_gap(output integer gap);
      logic q;
      begin
         for (int k = 0; k < 3; k++)
         begin
            q = tick_out_o;
            gap = 0;
            while (tick_out_o === q && gap < 20000)
            begin
               @(posedge mclk_i);
               gap = gap + 1;
            end
         end
      end
   endtask

   initial
   begin
      repeat (2) @(posedge mclk_i);
      reset_i <= 1'b0;
      rd(`PCM_CMD_RD_SENSE, 8'h00, "touch reset");
      rd(`PCM_CMD_RD_CLOCK, 8'h0c, "timing reset");
      rd(`PCM_CMD_RD_MASK, 8'hff, "enable reset");
      rd(`PCM_CMD_RD_CONFIG, 8'h00, "config reset");
      #1;
      cmp8({5'h00, tick_out_o, regulator_off_o, osc_power_down_o}, 8'h00, "pins");
      cmp8(fast_start_o, 8'hff, "fast start");
      ctrl_u.send(4'h8, 8'hff);
      ctrl_u.fetch(4'h0, ok, s);
      cmp8({7'h00, ok}, 8'h00, "unknown code");
      rd(`PCM_CMD_RD_SENSE, 8'h00, "touch kept");
      $display("test reset done");
      for (int i = 0; i < 3; i++)
      begin
         ctrl_u.send(`PCM_CMD_WR_CLOCK, cv[i]);
         rd(`PCM_CMD_RD_CLOCK, cv[i] & 8'hdf, "timing");
         cmp8({7'h00, osc_power_down_o}, {7'h00, cv[i][6]}, "osc stop");
         ctrl_u.send(`PCM_CMD_WR_MASK, mv[i]);
         rd(`PCM_CMD_RD_MASK, mv[i], "enable");
      end
      ctrl_u.send(`PCM_CMD_WR_CONFIG, 8'h04);
      #1;
      cmp8({7'h00, regulator_off_o}, 8'h01, "regulator");
      @(posedge mclk_i);
      supply_ok_i <= 1'b0;
      ctrl_u.send(`PCM_CMD_WR_MASK, 8'h3c);
      rd(`PCM_CMD_RD_MASK, 8'h3c, "enable asleep");
      cmp8(fast_start_o | fine_charge_o | counters_en_o, 8'h00, "seq asleep");
      supply_ok_i <= 1'b1;
      ctrl_u.send(`PCM_CMD_WR_MASK, 8'hff);
      ctrl_u.send(`PCM_CMD_WR_CONFIG, 8'h00);
      $display("test registers done");
      for (int i = 0; i < 2; i++)
      begin
         ctrl_u.send(`PCM_CMD_WR_CLOCK, ov[i]);
         out_gap(g);
         e = $rtoi(250.0e6 / (128.0e3 * mul[ov[i][2:0]])) * dv[ov[i][4:3]];
         cmp_rng(g, e - 3, e + 3, "tick period");
      end
      $display("test oscillator done");
      ctrl_u.send(`PCM_CMD_WR_CLOCK, 8'h4c);
      tin_run <= 1'b1;
      near_target_i <= 8'hff;
      at_final_i <= 8'hff;
      next_strobe(g, s);
      for (int k = 0; k < 8; k++)
      begin
         p = s;
         next_strobe(g, s);
         cmp8(s, {p[6:0], p[7]}, "strobe order");
         cmp_rng(g, 32, 32, "strobe spacing");
      end
      repeat (24) next_strobe(g, s);
      cmp8(counters_en_o, 8'hff, "operational");
      sense_hit_i <= 8'ha5;
      ctrl_u.send(`PCM_CMD_WR_MASK, 8'h0f);
      repeat (9) next_strobe(g, s);
      rd(`PCM_CMD_RD_SENSE, 8'h05, "masked touch");
      ctrl_u.send(`PCM_CMD_WR_CONFIG, 8'h01);
      near_target_i <= 8'h00;
      repeat (2) next_strobe(g, s);
      acc = 8'h00;
      repeat (8)
      begin
         next_strobe(g, s);
         acc = acc | s;
      end
      cmp8(acc, 8'h0f, "skipped channels");
      ctrl_u.send(`PCM_CMD_WR_MASK, 8'hff);
      repeat (2) @(posedge mclk_i);
      #1;
      cmp8(fast_start_o, 8'hf0, "restart");
      cmp8(counters_en_o, 8'h0f, "others kept");
      @(posedge mclk_i);
      supply_ok_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      cmp8(fast_start_o | fine_charge_o | counters_en_o, 8'h00, "supply lost");
      $display("test sampling done");
      conclude();
   end
endmodule

/* File: design/pcm_chan_seq.v */
`timescale 1ns/1ps
`include "pcm_regs.vh"

// Start-up sequencer of one sensing channel
module pcm_chan_seq
(
   input  wire mclk_i,
   input  wire reset_i,
   input  wire supply_ok_i,
   input  wire restart_i,
   input  wire sample_i,
   input  wire near_target_i,
   input  wire at_final_i,
   output wire fast_start_o,
   output wire fine_charge_o,
   output wire counters_en_o
);

   localparam SEQ_OFF  = `PCM_SEQ_OFF;
   localparam SEQ_FAST = `PCM_SEQ_FAST;
   localparam SEQ_FINE = `PCM_SEQ_FINE;
   localparam SEQ_RUN  = `PCM_SEQ_RUN;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg       fast_r;
   reg       fine_r;
   reg       run_r;

   // Fast and fine phases advance only on this channel's own samples, so a skipped channel waits
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         SEQ_OFF:  if (supply_ok_i) state_nxt = SEQ_FAST;
         SEQ_FAST: if (sample_i && near_target_i) state_nxt = SEQ_FINE;
         SEQ_FINE: if (sample_i && at_final_i) state_nxt = SEQ_RUN;
         SEQ_RUN:  state_nxt = SEQ_RUN;
         default:  state_nxt = SEQ_OFF;
      endcase
      // Newly enabled channel goes back through fast start
      if (restart_i && supply_ok_i)
         state_nxt = SEQ_FAST;
      // Losing the internal supply drops the channel back to off
      if (!supply_ok_i)
         state_nxt = SEQ_OFF;
   end

   // State register; phase flags are decoded ahead so the pins come from flops
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         state_r <= SEQ_OFF;
         fast_r  <= 1'b0;
         fine_r  <= 1'b0;
         run_r   <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         fast_r  <= (state_nxt == SEQ_FAST);
         fine_r  <= (state_nxt == SEQ_FINE);
         run_r   <= (state_nxt == SEQ_RUN);
      end
   end

   assign fast_start_o  = fast_r;
   assign fine_charge_o = fine_r;
   assign counters_en_o = run_r;

endmodule

/* File: design/pcm_regs.vh */
`ifndef PCM_REGS_VH
`define PCM_REGS_VH

// Command codes seen on the command port
`define PCM_CMD_RD_SENSE    4'h1
`define PCM_CMD_RD_CLOCK    4'h2
`define PCM_CMD_WR_CLOCK    4'h3
`define PCM_CMD_RD_MASK     4'h4
`define PCM_CMD_WR_MASK     4'h5
`define PCM_CMD_RD_CONFIG   4'h6
`define PCM_CMD_WR_CONFIG   4'h7

// Reset values
`define PCM_TOUCH_RST       8'h00
`define PCM_TIMING_RST      8'h0c
`define PCM_CHEN_RST        8'hff
`define PCM_CONFIG_RST      8'h00

// Timing setup field positions
`define PCM_TOUT_EN_BIT     7
`define PCM_TIN_EN_BIT      6
`define PCM_UNUSED_BIT      5
`define PCM_COARSE_HI       4
`define PCM_COARSE_LO       3
`define PCM_TRIM_HI         2
`define PCM_TRIM_LO         0

// Configuration field positions
`define PCM_REG_OFF_BIT     2
`define PCM_PWR_MODE_BIT    0

// Clock rates in Hz
`define PCM_OSC_NOM_HZ      64'd128000
`define PCM_MCLK_HZ         64'd250000000

// Coarse divider terminal counts (divide minus one)
`define PCM_DIV64_LAST      6'h3f
`define PCM_DIV16_LAST      6'h0f
`define PCM_DIV4_LAST       6'h03
`define PCM_DIV1_LAST       6'h00

// Internal clocks per sampling step, minus one
`define PCM_CLKS_PER_STEP   3'h7

// Start-up sequencer states
`define PCM_SEQ_OFF         2'h0
`define PCM_SEQ_FAST        2'h1
`define PCM_SEQ_FINE        2'h2
`define PCM_SEQ_RUN         2'h3

`endif

/* File: design/pcm_top.v */
`timescale 1ns/1ps
`include "pcm_regs.vh"

module pcm_top
(
   input  wire       mclk_i,
   input  wire       reset_i,
   input  wire       cmd_valid_i,
   input  wire [3:0] cmd_code_i,
   input  wire [7:0] cmd_wdata_i,
   output wire       rd_valid_o,
   output wire [7:0] rd_data_o,
   input  wire       tick_in_i,
   output wire       tick_out_o,
   input  wire       supply_ok_i,
   input  wire [7:0] sense_hit_i,
   input  wire [7:0] near_target_i,
   input  wire [7:0] at_final_i,
   output wire [7:0] sample_sel_o,
   output wire [7:0] fast_start_o,
   output wire [7:0] fine_charge_o,
   output wire [7:0] counters_en_o,
   output wire       regulator_off_o,
   output wire       osc_power_down_o
);

   // Phase increments for trim codes; carry rate = nominal * m, m in eighths
   localparam [63:0] INC_M4  = ((`PCM_OSC_NOM_HZ * 64'd4) << 29) / `PCM_MCLK_HZ;
   localparam [63:0] INC_M5  = ((`PCM_OSC_NOM_HZ * 64'd5) << 29) / `PCM_MCLK_HZ;
   localparam [63:0] INC_M6  = ((`PCM_OSC_NOM_HZ * 64'd6) << 29) / `PCM_MCLK_HZ;
   localparam [63:0] INC_M7  = ((`PCM_OSC_NOM_HZ * 64'd7) << 29) / `PCM_MCLK_HZ;
   localparam [63:0] INC_M8  = ((`PCM_OSC_NOM_HZ * 64'd8) << 29) / `PCM_MCLK_HZ;
   localparam [63:0] INC_M10 = ((`PCM_OSC_NOM_HZ * 64'd10) << 29) / `PCM_MCLK_HZ;
   localparam [63:0] INC_M12 = ((`PCM_OSC_NOM_HZ * 64'd12) << 29) / `PCM_MCLK_HZ;
   localparam [63:0] INC_M14 = ((`PCM_OSC_NOM_HZ * 64'd14) << 29) / `PCM_MCLK_HZ;

   // Register file
   reg  [7:0]  touch_state_r;
   reg  [7:0]  timing_setup_r;
   reg  [7:0]  channel_enable_map_r;
   reg  [7:0]  config_r;
   reg         rd_valid_r;
   reg  [7:0]  rd_data_r;
   reg  [7:0]  restart_r;

   // Clock generation
   reg  [31:0] osc_acc_r;
   reg  [31:0] osc_inc;
   reg         osc_tick_r;
   reg  [5:0]  coarse_cnt_r;
   reg  [5:0]  coarse_last;
   reg         clk_tick_r;
   reg         tick_in_prev_r;
   reg         clk_phase_r;
   reg         tick_out_r;

   // Sampler
   reg  [2:0]  step_cnt_r;
   reg  [2:0]  chan_ptr_r;
   reg  [2:0]  chan_ptr_nxt;
   reg         any_sampleable;
   reg  [7:0]  sample_sel_r;
   reg  [7:0]  touch_state_nxt;
   reg  [2:0]  cand;
   integer     i;
   integer     j;

   wire        tick_out_enable;
   wire        tick_in_enable;
   wire [1:0]  coarse_divider_select;
   wire [2:0]  osc_trim_select;
   wire        disabled_channel_power_mode;
   wire [32:0] osc_sum;
   wire        wr_clock;
   wire        wr_mask;
   wire        wr_config;
   wire [7:0]  sampleable;

   assign tick_out_enable             = timing_setup_r[`PCM_TOUT_EN_BIT];
   assign tick_in_enable              = timing_setup_r[`PCM_TIN_EN_BIT];
   assign coarse_divider_select       = timing_setup_r[`PCM_COARSE_HI:`PCM_COARSE_LO];
   assign osc_trim_select             = timing_setup_r[`PCM_TRIM_HI:`PCM_TRIM_LO];
   assign disabled_channel_power_mode = config_r[`PCM_PWR_MODE_BIT];

   assign wr_clock  = cmd_valid_i && (cmd_code_i == `PCM_CMD_WR_CLOCK);
   assign wr_mask   = cmd_valid_i && (cmd_code_i == `PCM_CMD_WR_MASK);
   assign wr_config = cmd_valid_i && (cmd_code_i == `PCM_CMD_WR_CONFIG);

   // Command writes; these registers sit in the always-powered domain
   // registers stay live
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         timing_setup_r       <= `PCM_TIMING_RST;
         channel_enable_map_r <= `PCM_CHEN_RST;
         config_r             <= `PCM_CONFIG_RST;
         restart_r            <= 8'h00;
      end
      else
      begin
         if (wr_clock)
         begin
            timing_setup_r <= cmd_wdata_i;
            timing_setup_r[`PCM_UNUSED_BIT] <= 1'b0;
         end
         if (wr_mask)
            channel_enable_map_r <= cmd_wdata_i;
         if (wr_config)
            config_r <= cmd_wdata_i;
         restart_r <= wr_mask ? (cmd_wdata_i & ~channel_enable_map_r) : 8'h00;
      end
   end

   // Read answers one cycle after the command; unknown codes get no answer
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         rd_valid_r <= 1'b0;
         rd_data_r  <= 8'h00;
      end
      else
      begin
         rd_valid_r <= 1'b0;
         if (cmd_valid_i)
         begin
            case (cmd_code_i)
               `PCM_CMD_RD_SENSE:
               begin
                  rd_valid_r <= 1'b1;
                  rd_data_r  <= touch_state_r;
               end
               `PCM_CMD_RD_CLOCK:
               begin
                  rd_valid_r <= 1'b1;
                  rd_data_r  <= timing_setup_r;
               end
               `PCM_CMD_RD_MASK:
               begin
                  rd_valid_r <= 1'b1;
                  rd_data_r  <= channel_enable_map_r;
               end
               `PCM_CMD_RD_CONFIG:
               begin
                  rd_valid_r <= 1'b1;
                  rd_data_r  <= config_r;
               end
               default:
               begin
                  rd_valid_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Trim selects the phase step
   // trim multiplier table
   always @*
   begin
      case (osc_trim_select)
         3'h0:    osc_inc = INC_M4[31:0];
         3'h1:    osc_inc = INC_M5[31:0];
         3'h2:    osc_inc = INC_M6[31:0];
         3'h3:    osc_inc = INC_M7[31:0];
         3'h4:    osc_inc = INC_M8[31:0];
         3'h5:    osc_inc = INC_M10[31:0];
         3'h6:    osc_inc = INC_M12[31:0];
         3'h7:    osc_inc = INC_M14[31:0];
         default: osc_inc = INC_M8[31:0];
      endcase
   end

   // Coarse divider terminal count
   // divide by 64/16/4/1
   always @*
   begin
      case (coarse_divider_select)
         2'h0:    coarse_last = `PCM_DIV64_LAST;
         2'h1:    coarse_last = `PCM_DIV16_LAST;
         2'h2:    coarse_last = `PCM_DIV4_LAST;
         2'h3:    coarse_last = `PCM_DIV1_LAST;
         default: coarse_last = `PCM_DIV16_LAST;
      endcase
   end

   assign osc_sum = {1'b0, osc_acc_r} + {1'b0, osc_inc};

   // Oscillator model: carry out of the accumulator is one oscillator cycle.
   // Frequency error is below one part in ten thousand, jitter one mclk period.
   // nominal oscillator
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         osc_acc_r  <= 32'h0000_0000;
         osc_tick_r <= 1'b0;
      end
      else if (tick_in_enable)
      begin
         osc_acc_r  <= 32'h0000_0000;
         osc_tick_r <= 1'b0;
      end
      else
      begin
         osc_acc_r  <= osc_sum[31:0];
         osc_tick_r <= osc_sum[32];
      end
   end

   // Internal clock: divided oscillator, or falling edge of the input pin
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         coarse_cnt_r   <= 6'h00;
         clk_tick_r     <= 1'b0;
         tick_in_prev_r <= 1'b0;
      end
      else
      begin
         tick_in_prev_r <= tick_in_i;
         if (tick_in_enable)
         begin
            coarse_cnt_r <= 6'h00;
            clk_tick_r   <= tick_in_prev_r && !tick_in_i;
         end
         else if (osc_tick_r)
         begin
            if (coarse_cnt_r >= coarse_last)
            begin
               coarse_cnt_r <= 6'h00;
               clk_tick_r   <= 1'b1;
            end
            else
            begin
               coarse_cnt_r <= coarse_cnt_r + 6'h01;
               clk_tick_r   <= 1'b0;
            end
         end
         else
            clk_tick_r <= 1'b0;
      end
   end

   // Clock output pin mirrors the internal clock as a square wave
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         clk_phase_r <= 1'b0;
         tick_out_r  <= 1'b0;
      end
      else
      begin
         if (clk_tick_r)
            clk_phase_r <= ~clk_phase_r;
         tick_out_r <= tick_out_enable && clk_phase_r;
      end
   end

   // Channels the sampler may visit
   // skip disabled in low power
   assign sampleable = disabled_channel_power_mode ? channel_enable_map_r : 8'hff;

   // Next channel: first sampleable one after the pointer, ascending with wrap
   // ascending round robin
   always @*
   begin
      chan_ptr_nxt   = chan_ptr_r;
      any_sampleable = 1'b0;
      cand           = 3'h0;
      for (i = 8; i >= 1; i = i - 1)
      begin
         cand = chan_ptr_r + i[2:0];
         if (sampleable[cand])
         begin
            chan_ptr_nxt   = cand;
            any_sampleable = 1'b1;
         end
      end
   end

   // Sampler steps one channel per eight internal clocks while supply is up
   // clock over eight
   always @(posedge mclk_i)
   begin
      if (reset_i)
      begin
         step_cnt_r   <= 3'h0;
         chan_ptr_r   <= 3'h0;
         sample_sel_r <= 8'h00;
      end
      else
      begin
         sample_sel_r <= 8'h00;
         if (!supply_ok_i)
         begin
            step_cnt_r <= 3'h0;
            chan_ptr_r <= 3'h0;
         end
         else if (clk_tick_r)
         begin
            step_cnt_r <= step_cnt_r + 3'h1;
            if (step_cnt_r == `PCM_CLKS_PER_STEP)
            begin
               if (sampleable[chan_ptr_r])
                  sample_sel_r[chan_ptr_r] <= 1'b1;
               if (any_sampleable)
                  chan_ptr_r <= chan_ptr_nxt;
            end
         end
      end
   end

   // A sampled result lands only for enabled, running channels
   // disabled channels never update
   always @*
   begin
      touch_state_nxt = touch_state_r;
      // Own loop index; sharing one with the pointer search would retrigger both
      for (j = 0; j < 8; j = j + 1)
      begin
         if (sample_sel_r[j] && channel_enable_map_r[j] && counters_en_o[j])
            touch_state_nxt[j] = sense_hit_i[j];
      end
   end

   // Touch state register; no command path reaches it
   // per-channel touch bits
   always @(posedge mclk_i)
   begin
      if (reset_i)
         touch_state_r <= `PCM_TOUCH_RST;
      else
         touch_state_r <= touch_state_nxt;
   end

   // One start-up sequencer per channel
   // independent per channel
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1)
      begin : g_chan
         pcm_chan_seq u_seq
         (
            .mclk_i        (mclk_i),
            .reset_i       (reset_i),
            .supply_ok_i   (supply_ok_i),
            .restart_i     (restart_r[g]),
            .sample_i      (sample_sel_r[g]),
            .near_target_i (near_target_i[g]),
            .at_final_i    (at_final_i[g]),
            .fast_start_o  (fast_start_o[g]),
            .fine_charge_o (fine_charge_o[g]),
            .counters_en_o (counters_en_o[g])
         );
      end
   endgenerate

   assign rd_valid_o       = rd_valid_r;
   assign rd_data_o        = rd_data_r;
   assign tick_out_o       = tick_out_r;
   assign sample_sel_o     = sample_sel_r;
   assign regulator_off_o  = config_r[`PCM_REG_OFF_BIT];
   assign osc_power_down_o = tick_in_enable;

endmodule
